// [inc/sac_pkg.sv]
// Purpose: Shared constants and types of the converter control block
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes:   Register layout mirrors the converter's byte registers
package sac_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [4:0] SAC_OFS_MODE     = 5'h00;
  localparam logic [4:0] SAC_OFS_RES_HIGH = 5'h04;
  localparam logic [4:0] SAC_OFS_RES_LOW  = 5'h08;
  localparam logic [4:0] SAC_OFS_REF_SEL  = 5'h0C;
  localparam logic [4:0] SAC_OFS_IRQ      = 5'h10;
  localparam logic [4:0] SAC_OFS_PIN_CFG  = 5'h14;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SAC_BIT_ENABLE = 7;
  localparam int SAC_BIT_START  = 6;
  localparam int SAC_BIT_DONE   = 5;
  localparam int SAC_LSB_CHSEL  = 0;
  localparam int SAC_BIT_GATE   = 6;
  localparam int SAC_LSB_CLKDIV = 4;
  localparam int SAC_LSB_RESLO  = 0;
  localparam int SAC_BIT_IRQ_EN = 0;
  localparam int SAC_BIT_IRQ_FL = 1;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0]  SAC_RST_CHSEL  = 4'h0;
  localparam logic [1:0]  SAC_RST_CLKDIV = 2'h0;
  localparam logic [2:0]  SAC_RST_REF    = 3'h0;
  localparam logic [5:0]  SAC_RST_PINCFG = 6'h00;
  localparam logic [11:0] SAC_RST_RESULT = 12'h000;

  // ---------------------------------------------------------------
  // Channel codes and timing
  // ---------------------------------------------------------------
  localparam logic [3:0] SAC_CH_LAST_PIN = 4'h5;
  localparam logic [3:0] SAC_CH_SUPPLY   = 4'h6;
  localparam logic [3:0] SAC_CH_GROUND   = 4'h7;
  localparam logic [3:0] SAC_CH_INTERNAL = 4'h8;
  localparam int SAC_RES_BITS        = 12;
  localparam int SAC_CONV_PERIODS    = 16;
  localparam int SAC_TICKS_PER_PER   = 4;
  localparam int SAC_CONV_TICKS      = SAC_CONV_PERIODS * SAC_TICKS_PER_PER;
  localparam int SAC_SAMPLE_PERIODS  = 2;
  localparam int SAC_DIV_16          = 16;
  localparam int SAC_DIV_8           = 8;
  localparam int SAC_DIV_1           = 1;
  localparam int SAC_DIV_2           = 2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SAC_REF_2V     = 2'h0,
    SAC_REF_3V     = 2'h1,
    SAC_REF_4V     = 2'h2,
    SAC_REF_SUPPLY = 2'h3
  } sac_ref_e;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } sac_bus_req_s;

  typedef struct packed {
    logic        power;
    logic        sample;
    logic [11:0] trial_code;
    logic [3:0]  input_select;
    logic        channel_gate;
    logic        channel_valid;
    sac_ref_e    ref_source;
    logic [5:0]  analog_pin_config;
  } sac_analog_s;

endpackage : sac_pkg

// [hw/sac_clk_div.sv]
// Purpose: Converter clock enable from the oscillator clock
// Assumes: Divisor between 1 and 16
// Notes:   Restart realigns the tick to a new conversion
`timescale 1ns/10ps
module sac_clk_div (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  // Control
  input  wire logic       restart_in,
  input  wire logic [1:0] sample_clock_divider_in,
  // Converter clock enable
  output logic            tick_out
);
  import sac_pkg::*;

  logic [3:0] count_q;
  logic [3:0] last_cnt;

  always_comb begin
    case (sample_clock_divider_in)
      2'h0:    last_cnt = 4'(SAC_DIV_16 - 1);
      2'h1:    last_cnt = 4'(SAC_DIV_8 - 1);
      2'h2:    last_cnt = 4'(SAC_DIV_1 - 1);
      default: last_cnt = 4'(SAC_DIV_2 - 1);
    endcase
  end

  assign tick_out = !restart_in && (count_q >= last_cnt);

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      count_q <= 4'h0;
    end else if (restart_in || tick_out) begin
      count_q <= 4'h0;
    end else begin
      count_q <= count_q + 4'h1;
    end
  end

endmodule : sac_clk_div

// [hw/sac_sar.sv]
// Purpose: Successive-approximation sequencer for one conversion
// Assumes: Comparator input already synchronised
// Notes:   Sixteen periods of four converter clocks per conversion
`timescale 1ns/10ps
module sac_sar (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  // Control
  input  wire logic        tick_in,
  input  wire logic        start_in,
  input  wire logic        abort_in,
  input  wire logic        cmp_above_in,
  // Status and data
  output logic             busy_out,
  output logic             sample_out,
  output logic             done_out,
  output logic [11:0]      trial_out,
  output logic [11:0]      result_out
);
  import sac_pkg::*;

  typedef enum logic [2:0] {
    SAR_IDLE   = 3'b001,
    SAR_SAMPLE = 3'b010,
    SAR_CONV   = 3'b100
  } sar_state_e;

  sar_state_e  state_q;
  logic [5:0]  tick_cnt_q;
  logic [3:0]  period;
  logic [3:0]  bit_idx;
  logic        decide;

  assign period   = tick_cnt_q[5:2];
  assign bit_idx  = 4'(SAC_RES_BITS - 1 + SAC_SAMPLE_PERIODS) - period;
  assign decide   = tick_in && (state_q == SAR_CONV) && (tick_cnt_q[1:0] == 2'h3)
                    && (period < 4'(SAC_RES_BITS + SAC_SAMPLE_PERIODS));
  assign busy_out   = (state_q != SAR_IDLE);
  assign sample_out = (state_q == SAR_SAMPLE);

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state_q    <= SAR_IDLE;
      tick_cnt_q <= 6'h00;
      done_out   <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state_q)
        SAR_IDLE: begin
          if (start_in) begin
            state_q    <= SAR_SAMPLE;
            tick_cnt_q <= 6'h00;
          end
        end
        SAR_SAMPLE: begin
          if (abort_in) begin
            state_q <= SAR_IDLE;
          end else if (tick_in) begin
            tick_cnt_q <= tick_cnt_q + 6'h01;
            if (tick_cnt_q == 6'(SAC_SAMPLE_PERIODS * SAC_TICKS_PER_PER - 1)) begin
              state_q <= SAR_CONV;
            end
          end
        end
        SAR_CONV: begin
          if (abort_in) begin
            state_q <= SAR_IDLE;
          end else if (tick_in) begin
            tick_cnt_q <= tick_cnt_q + 6'h01;
            if (tick_cnt_q == 6'(SAC_CONV_TICKS - 1)) begin
              state_q  <= SAR_IDLE;
              done_out <= 1'b1;
            end
          end
        end
        default: state_q <= SAR_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Approximation register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      trial_out <= 12'h000;
    end else if (start_in && state_q == SAR_IDLE) begin
      trial_out <= 12'h800;
    end else if (decide) begin
      trial_out[bit_idx] <= cmp_above_in;
      if (bit_idx != 4'h0) begin
        trial_out[bit_idx - 4'h1] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      result_out <= SAC_RST_RESULT;
    end else if (tick_in && state_q == SAR_CONV
                 && tick_cnt_q == 6'(SAC_CONV_TICKS - 1)) begin
      result_out <= trial_out;
    end
  end

endmodule : sac_sar

// [hw/sac_top.sv]
// Purpose: Control of a 12-bit successive-approximation converter
// Assumes: Avalon-MM slave, one wait state, byte lane 0 carries data
// Notes:   Runs on the oscillator clock, independent of the CPU clock
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps

// Overview of operation
// - Start needs start write with enable set
// - Start bit self-clears at completion
// - Completion sets done, flag, result registers
// - Flag with irq enable requests interrupt
// - Service entry clears interrupt flag
// - Select code plus gate picks input
// - Four converter clock rates set speed
// - Four high reference sources selectable
// - Twelve-bit unsigned code, 4096 steps
// - Converter keeps running in idle
// - Completion with irq enable wakes system
// - Divider codes give fosc/16, /8, /1, /2
// - Conversion lasts 64 converter clocks
// - Reference select decode, bit 2 supply
// - Result split high byte, low nibble
module sac_top #(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  reset_in,
  // Avalon-MM register slave
  input  wire sac_pkg::sac_bus_req_s avs_req_in,
  output logic                       avs_waitrequest_out,
  output logic [31:0]                avs_readdata_out,
  // CPU side
  input  wire logic                  isr_enter_in,
  output logic                       irq_req_out,
  output logic                       wake_out,
  // Analog converter core
  input  wire logic                  cmp_above_in,
  output sac_pkg::sac_analog_s       analog_out
);
  import sac_pkg::*;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic        converter_enable_q;
  logic        conversion_start_q;
  logic        conversion_done_q;
  logic [3:0]  input_select_q;
  logic        channel_gate_q;
  logic [1:0]  sample_clock_divider_q;
  logic [2:0]  ref_level_select_q;
  logic        converter_irq_enable_q;
  logic        converter_irq_flag_q;
  logic [5:0]  analog_pin_config_q;
  logic [11:0] result_q;

  // ---------------------------------------------------------------
  // Internal signals
  // ---------------------------------------------------------------
  logic [SYNC_STAGES-1:0] cmp_sync_q;
  logic        bus_req;
  logic        bus_ack_q;
  logic        wr_take;
  logic        rd_take;
  logic        wr_lane;
  logic [7:0]  wr_byte;
  logic        start_req;
  logic        start_go;
  logic        abort;
  logic        tick;
  logic        busy;
  logic        sample;
  logic        done_pulse;
  logic [11:0] trial;
  logic [11:0] sar_result;
  logic [31:0] rd_data_d;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic hits(input logic [4:0] addr, input logic [4:0] ofs);
    hits = (addr[4:2] == ofs[4:2]);
  endfunction : hits

  function automatic sac_ref_e ref_decode(input logic [2:0] sel);
    if (sel[2]) begin
      ref_decode = SAC_REF_SUPPLY;
    end else begin
      case (sel[1:0])
        2'h2:    ref_decode = SAC_REF_4V;
        2'h1:    ref_decode = SAC_REF_3V;
        2'h0:    ref_decode = SAC_REF_2V;
        default: ref_decode = SAC_REF_2V;
      endcase
    end
  endfunction : ref_decode

  function automatic logic chan_valid(input logic [3:0] sel, input logic gate);
    chan_valid = gate && (sel <= SAC_CH_INTERNAL);
  endfunction : chan_valid

  // ---------------------------------------------------------------
  // Bus handshake: one wait state per access
  // ---------------------------------------------------------------
  // Both strobes high is refused: no wait state, no register write, but read data still reloads
  assign bus_req             = avs_req_in.read ^ avs_req_in.write;
  assign avs_waitrequest_out = bus_req && !bus_ack_q;
  assign wr_take             = avs_req_in.write && bus_ack_q;
  assign rd_take             = avs_req_in.read && !bus_ack_q;
  assign wr_lane             = wr_take && avs_req_in.byteenable[0];
  assign wr_byte             = avs_req_in.writedata[7:0];

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      bus_ack_q <= 1'b0;
    end else begin
      bus_ack_q <= bus_req && !bus_ack_q;
    end
  end

  // ---------------------------------------------------------------
  // Comparator synchroniser
  // ---------------------------------------------------------------
  // Comparator settles asynchronously to this clock
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cmp_sync_q <= '0;
    end else begin
      cmp_sync_q <= {cmp_sync_q[SYNC_STAGES-2:0], cmp_above_in};
    end
  end

  // ---------------------------------------------------------------
  // Start decision
  // ---------------------------------------------------------------
  // Start needs enable both stored and in the same write
  // Clearing enable mid-conversion aborts and keeps the result
  assign start_req = wr_lane && hits(avs_req_in.address, SAC_OFS_MODE)
                     && wr_byte[SAC_BIT_START];
  assign start_go  = start_req && wr_byte[SAC_BIT_ENABLE]
                     && converter_enable_q && !busy;
  assign abort     = busy && !converter_enable_q;

  // ---------------------------------------------------------------
  // Mode register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      converter_enable_q <= 1'b0;
      input_select_q     <= SAC_RST_CHSEL;
    end else if (wr_lane && hits(avs_req_in.address, SAC_OFS_MODE)) begin
      converter_enable_q <= wr_byte[SAC_BIT_ENABLE];
      input_select_q     <= wr_byte[SAC_LSB_CHSEL +: 4];
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      conversion_start_q <= 1'b0;
    end else if (start_go) begin
      conversion_start_q <= 1'b1;
    end else if (done_pulse || abort) begin
      conversion_start_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      conversion_done_q <= 1'b0;
    end else if (start_go) begin
      // A start in the completion cycle wins and begins afresh
      conversion_done_q <= 1'b0;
    end else if (done_pulse) begin
      conversion_done_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Result, gate and clock rate register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      channel_gate_q         <= 1'b0;
      sample_clock_divider_q <= SAC_RST_CLKDIV;
    end else if (wr_lane && hits(avs_req_in.address, SAC_OFS_RES_LOW)) begin
      channel_gate_q         <= wr_byte[SAC_BIT_GATE];
      sample_clock_divider_q <= wr_byte[SAC_LSB_CLKDIV +: 2];
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      result_q <= SAC_RST_RESULT;
    end else if (done_pulse) begin
      result_q <= sar_result;
    end
  end

  // ---------------------------------------------------------------
  // Reference and pin configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ref_level_select_q <= SAC_RST_REF;
    end else if (wr_lane && hits(avs_req_in.address, SAC_OFS_REF_SEL)) begin
      ref_level_select_q <= wr_byte[2:0];
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      analog_pin_config_q <= SAC_RST_PINCFG;
    end else if (wr_lane && hits(avs_req_in.address, SAC_OFS_PIN_CFG)) begin
      analog_pin_config_q <= wr_byte[5:0];
    end
  end

  // ---------------------------------------------------------------
  // Interrupt enable and flag
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      converter_irq_enable_q <= 1'b0;
    end else if (wr_lane && hits(avs_req_in.address, SAC_OFS_IRQ)) begin
      converter_irq_enable_q <= wr_byte[SAC_BIT_IRQ_EN];
    end
  end

  // Set by completion beats any clear in the same cycle
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      converter_irq_flag_q <= 1'b0;
    end else if (done_pulse) begin
      converter_irq_flag_q <= 1'b1;
    end else if (isr_enter_in) begin
      converter_irq_flag_q <= 1'b0;
    end else if (wr_lane && hits(avs_req_in.address, SAC_OFS_IRQ)) begin
      // Writing zero clears, writing one leaves it
      converter_irq_flag_q <= converter_irq_flag_q & wr_byte[SAC_BIT_IRQ_FL];
    end
  end

  // Level request, held until service entry or a firmware clear
  assign irq_req_out = converter_irq_flag_q && converter_irq_enable_q;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      wake_out <= 1'b0;
    end else begin
      // One-cycle pulse lifts the system out of its low-power mode
      wake_out <= done_pulse && converter_irq_enable_q;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    rd_data_d = 32'h0000_0000;
    if (hits(avs_req_in.address, SAC_OFS_MODE)) begin
      rd_data_d[SAC_BIT_ENABLE]       = converter_enable_q;
      rd_data_d[SAC_BIT_START]        = conversion_start_q;
      rd_data_d[SAC_BIT_DONE]         = conversion_done_q;
      rd_data_d[SAC_LSB_CHSEL +: 4]   = input_select_q;
    end else if (hits(avs_req_in.address, SAC_OFS_RES_HIGH)) begin
      rd_data_d[7:0]                  = result_q[11:4];
    end else if (hits(avs_req_in.address, SAC_OFS_RES_LOW)) begin
      rd_data_d[SAC_BIT_GATE]         = channel_gate_q;
      rd_data_d[SAC_LSB_CLKDIV +: 2]  = sample_clock_divider_q;
      rd_data_d[SAC_LSB_RESLO +: 4]   = result_q[3:0];
    end else if (hits(avs_req_in.address, SAC_OFS_REF_SEL)) begin
      rd_data_d[2:0]                  = ref_level_select_q;
    end else if (hits(avs_req_in.address, SAC_OFS_IRQ)) begin
      rd_data_d[SAC_BIT_IRQ_EN]       = converter_irq_enable_q;
      rd_data_d[SAC_BIT_IRQ_FL]       = converter_irq_flag_q;
    end else if (hits(avs_req_in.address, SAC_OFS_PIN_CFG)) begin
      rd_data_d[5:0]                  = analog_pin_config_q;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      avs_readdata_out <= 32'h0000_0000;
    // Loaded in the first request cycle, stands at the ack edge
    end else if (rd_take) begin
      avs_readdata_out <= rd_data_d;
    end
  end

  // ---------------------------------------------------------------
  // Converter clock and sequencer
  // ---------------------------------------------------------------
  // Runs from the oscillator clock only, so idle mode leaves it going
  sac_clk_div u_clk_div (
    .clk_sys_in              (clk_sys_in),
    .reset_in                (reset_in),
    .restart_in              (start_go),
    .sample_clock_divider_in (sample_clock_divider_q),
    .tick_out                (tick)
  );

  sac_sar u_sar (
    .clk_sys_in   (clk_sys_in),
    .reset_in     (reset_in),
    .tick_in      (tick),
    .start_in     (start_go),
    .abort_in     (abort),
    .cmp_above_in (cmp_sync_q[SYNC_STAGES-1]),
    .busy_out     (busy),
    .sample_out   (sample),
    .done_out     (done_pulse),
    .trial_out    (trial),
    .result_out   (sar_result)
  );

  // ---------------------------------------------------------------
  // Analog core controls
  // ---------------------------------------------------------------
  // Reference choice for the internal channel is left to firmware
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      analog_out <= '0;
    end else begin
      analog_out.power             <= converter_enable_q;
      analog_out.sample            <= sample;
      analog_out.trial_code        <= trial;
      analog_out.input_select      <= input_select_q;
      analog_out.channel_gate      <= channel_gate_q;
      analog_out.channel_valid     <= chan_valid(input_select_q, channel_gate_q);
      analog_out.ref_source        <= ref_decode(ref_level_select_q);
      analog_out.analog_pin_config <= analog_pin_config_q;
    end
  end

endmodule : sac_top

// [test/sac_core_model.sv]
// Purpose: Comparator model of the analog converter core
// Assumes: Input level given by the bench
// Notes:   Toggles while unpowered
`timescale 1ns/10ps
module sac_core_model (
  // Clock and level
  input  wire logic                 clk_sys_in,
  input  wire logic [11:0]          level_in,
  // Core side
  input  wire sac_pkg::sac_analog_s analog_in,
  output logic                      cmp_above_out
);
  import sac_pkg::*;
  logic toggle_q = 1'b0;
  always @(posedge clk_sys_in) toggle_q <= ~toggle_q;
  assign cmp_above_out = analog_in.power ? (level_in >= analog_in.trial_code) : toggle_q;
endmodule : sac_core_model

// [test/sac_props.sv]
// Purpose: Port checks of the converter control
// Assumes: One clock, async high reset
// Notes:   Bound to sac_top
`timescale 1ns/10ps
module sac_props (
  // Clock, reset and ports
  input wire logic                  clk_sys_in,
  input wire logic                  reset_in,
  input wire sac_pkg::sac_bus_req_s avs_req_in,
  input wire logic                  avs_waitrequest_out,
  input wire logic [31:0]           avs_readdata_out,
  input wire logic                  isr_enter_in,
  input wire logic                  irq_req_out,
  input wire logic                  wake_out,
  input wire logic                  cmp_above_in,
  input wire sac_pkg::sac_analog_s  analog_out
);
  import sac_pkg::*;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  sequence s_sample_hold; analog_out.sample [*8]; endsequence
  sequence s_sample_end; ##[8:130] $fell(analog_out.sample); endsequence
  property p_sample_min; $rose(analog_out.sample) |-> s_sample_hold; endproperty
  property p_sample_end; $rose(analog_out.sample) |-> s_sample_end; endproperty
  property p_wake_irq; wake_out |-> irq_req_out; endproperty
  property p_wake_once; wake_out |=> !wake_out; endproperty
  property p_isr; isr_enter_in |=> (!irq_req_out || wake_out); endproperty
  property p_off_idle; !analog_out.power |-> !analog_out.sample; endproperty
  property p_chan;
    analog_out.channel_valid == (analog_out.channel_gate && analog_out.input_select <= 4'h8);
  endproperty
  property p_rd_byte; !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h000000; endproperty
  a_sample_min: assert property (p_sample_min) else $error("sampling too short");
  a_sample_end: assert property (p_sample_end) else $error("sampling too long");
  a_wake_irq: assert property (p_wake_irq) else $error("wake without irq");
  a_wake_once: assert property (p_wake_once) else $error("wake too long");
  a_isr: assert property (p_isr) else $error("flag kept at service");
  a_off_idle: assert property (p_off_idle) else $error("sampling while off");
  a_chan: assert property (p_chan) else $error("channel decode");
  a_rd_byte: assert property (p_rd_byte) else $error("upper read bits");
endmodule : sac_props
bind sac_top sac_props sac_props_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
  .avs_req_in(avs_req_in), .avs_waitrequest_out(avs_waitrequest_out),
  .avs_readdata_out(avs_readdata_out), .isr_enter_in(isr_enter_in),
  .irq_req_out(irq_req_out), .wake_out(wake_out), .cmp_above_in(cmp_above_in),
  .analog_out(analog_out));

// [test/testbench.sv]
// Purpose: Register-level tests of the converter control
// Assumes: One wait state bus, comparator model
// Notes:   Each divider code converts once, code 3 twice
`timescale 1ns/10ps
module testbench;
  import sac_pkg::*;
  logic         clk_sys_in = 1'b0;
  logic         reset_in   = 1'b1;
  logic         isr_enter  = 1'b0;
  sac_bus_req_s req        = '0;
  logic [11:0]  level      = 12'h000;
  logic         avs_wait, irq_req, wake, cmp_above;
  logic [31:0]  rdata;
  sac_analog_s  ana;
  logic [7:0]   q;
  int           err_total = 0, num_checks = 0, cyc = 0, t0, dv;
  logic [3:0]   ch_t [4] = '{4'h8, 4'h0, 4'h5, 4'h7};
  logic [7:0]   rf_t [4] = '{8'h04, 8'h02, 8'h01, 8'h00};
  logic [11:0]  lv_t [4] = '{12'hFFF, 12'h000, 12'hA5C, 12'h3C1};
  int           dv_t [4] = '{16, 8, 1, 2};
  logic [4:0]   of_t [7] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18};
  sac_top sac_top_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .avs_req_in(req),
    .avs_waitrequest_out(avs_wait), .avs_readdata_out(rdata), .isr_enter_in(isr_enter),
    .irq_req_out(irq_req), .wake_out(wake), .cmp_above_in(cmp_above), .analog_out(ana));
  sac_core_model sac_core_model_i (.clk_sys_in(clk_sys_in), .level_in(level),
    .analog_in(ana), .cmp_above_out(cmp_above));
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) cyc <= cyc + 1;
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    req.read <= ~wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= {24'h000000, d};
    req.byteenable <= 4'hF;
    do @(posedge clk_sys_in); while (avs_wait !== 1'b0);
    q = rdata[7:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk_sys_in);
  endtask : bus
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string what);
    bus(1'b0, a, 8'h00);
    check(q, exp, what);
  endtask : rd
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    @(posedge clk_sys_in);
    foreach (of_t[i]) rd(of_t[i], 8'h00, "reset value");
    bus(1'b1, 5'h18, 8'hFF);
    rd(5'h18, 8'h00, "unmapped");
    bus(1'b1, 5'h00, 8'h45);
    rd(5'h00, 8'h05, "start while off");
    rd(5'h10, 8'h00, "flag while off");
    bus(1'b1, 5'h00, 8'h85);
    rd(5'h00, 8'h85, "enable alone");
    $display("test refuse done");
    for (int i = 0; i < 4; i++) begin
      level <= lv_t[i];
      dv = dv_t[i];
      bus(1'b1, 5'h08, {2'b01, i[1:0], 4'h0});
      bus(1'b1, 5'h0C, rf_t[i]);
      bus(1'b1, 5'h14, (ch_t[i] < 4'h6) ? (8'h01 << ch_t[i]) : 8'h00);
      bus(1'b1, 5'h10, 8'h01);
      bus(1'b1, 5'h00, {4'h8, ch_t[i]});
      bus(1'b1, 5'h00, {4'hC, ch_t[i]});
      t0 = cyc;
      rd(5'h00, {4'hC, ch_t[i]}, "done at start");
      while (wake !== 1'b1) @(posedge clk_sys_in);
      check((cyc - t0 >= 64 * dv) && (cyc - t0 <= 64 * dv + 3), 1, "time");
      check(irq_req, 1'b1, "irq");
      check(ana.ref_source, i[1:0] ^ 2'h3, "ref");
      check(ana.analog_pin_config, (ch_t[i] < 4'h6) ? (6'h01 << ch_t[i]) : 6'h00, "pins");
      rd(5'h00, {4'hA, ch_t[i]}, "mode end");
      rd(5'h04, level[11:4], "high");
      rd(5'h08, {2'b01, i[1:0], level[3:0]}, "low");
      rd(5'h10, 8'h03, "flag");
      isr_enter <= 1'b1;
      @(posedge clk_sys_in);
      isr_enter <= 1'b0;
      @(posedge clk_sys_in);
      check(irq_req, 1'b0, "service");
      $display("test divider %0d done", i);
    end
    bus(1'b1, 5'h10, 8'h00);
    bus(1'b1, 5'h00, 8'hC0);
    q = 8'h00;
    for (int n = 0; n < 300 && q[5] !== 1'b1; n++) bus(1'b0, 5'h00, 8'h00);
    check(q, 8'hA0, "poll done");
    check(irq_req, 1'b0, "irq masked");
    rd(5'h10, 8'h02, "flag masked");
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, 5'h00, {4'h0, c[3:0]});
      @(posedge clk_sys_in);
      check(ana.channel_valid, c <= 8, "channel");
    end
    $display("test channels done");
    end_of_test();
  end
endmodule : testbench
